// ==== include/home_node_regs_pkg.sv ====
package home_node_regs_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int REQ_ADDR_W = 52;

    // ****************************************************************
    // register word addresses, each 64-bit register as two words
    // ****************************************************************
    localparam logic [11:0] PROP_LO_OFF  = 12'hCE8;
    localparam logic [11:0] PROP_HI_OFF  = 12'hCEC;
    localparam logic [11:0] MASK0_LO_OFF = 12'hF80;
    localparam logic [11:0] MASK0_HI_OFF = 12'hF84;
    localparam logic [11:0] MASK1_LO_OFF = 12'hF88;
    localparam logic [11:0] MASK1_HI_OFF = 12'hF8C;
    localparam logic [11:0] OVERRIDE_OFF = 12'hF00;

    // ****************************************************************
    // field layout
    // ****************************************************************
    localparam int TARGET_STRIDE = 8;
    localparam int NUM_TARGETS   = 6;
    localparam int NUM_RANGE     = 2;
    localparam int META_POS      = 2;
    localparam int GROUP_POS     = 1;
    localparam int NEWER_POS     = 0;
    localparam int MASK_LSB      = 6;
    localparam int MASK_MSB      = 51;
    localparam int MASK_W        = 46;
    localparam int OVERRIDE_POS  = 0;

    localparam logic [63:0] PROP_WMASK = 64'h0707_0707_0707_0707;
    localparam logic [63:0] MASK_WMASK = 64'h000F_FFFF_FFFF_FFC0;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [63:0]     PROP_RESET        = 64'h0;
    localparam logic [MASK_W-1:0] MASK0_FIELD_RESET = 46'h3FFFFFFFFFF;
    localparam logic [MASK_W-1:0] MASK1_FIELD_RESET = 46'h3FFFFFFFFF;
    localparam logic            OVERRIDE_RESET    = 1'b0;

    // ****************************************************************
    // responses
    // ****************************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [2:0] {
        SEL_PROP_LO,
        SEL_PROP_HI,
        SEL_MASK0_LO,
        SEL_MASK0_HI,
        SEL_MASK1_LO,
        SEL_MASK1_HI,
        SEL_OVERRIDE,
        SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic                  valid;
        logic [REQ_ADDR_W-1:0] addr;
    } hash_req_s;

    typedef struct packed {
        logic              valid;
        logic [MASK_W-1:0] grp0;
        logic [MASK_W-1:0] grp1;
    } masked_addr_s;

endpackage

// ==== design/home_node_target_property_regs.sv ====
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - property register holds settings for six numbered and two range targets.
// - only secure accesses, or any access while override is set, read or change property and mask registers.
// - numbered target meta bit set means metadata termination for that target.
// - range target meta bits 50 and 58 enable termination for range targets.
// - group select bit zero is group A, one is group B.
// - newer-protocol flag is stored read-write but drives nothing.
// - every defined property field resets to zero.
// - each group mask on address bits 51:6 is applied before hashing.
// - group 0 mask field resets to 46'h3FFFFFFFFFF.
// - group 1 mask field resets to 46'h3FFFFFFFFF as printed.
module home_node_target_property_regs
    import home_node_regs_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire hash_req_s         hash_req,
    output masked_addr_s           masked_addr,
    output logic [NUM_TARGETS-1:0] target_meta_terminate,
    output logic [NUM_RANGE-1:0]   range_target_meta_terminate,
    output logic [NUM_TARGETS-1:0] target_group_select,
    output logic [NUM_RANGE-1:0]   range_target_group_select,
    output logic                   secure_override
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              arready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [DATA_W-1:0] rdata;
        logic              aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic              aw_secure;
        logic              w_have;
        logic [DATA_W-1:0] w_data;
        logic [3:0]        w_strb;
        logic [63:0]       props;
        logic [63:0]       mask0;
        logic [63:0]       mask1;
        logic              override_en;
        masked_addr_s      masked;
    } state_s;

    state_s   st;
    state_s   next_st;
    reg_sel_e wr_sel;
    reg_sel_e rd_sel;
    logic     wr_ok;
    logic     rd_ok;
    logic     wr_fire;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic reg_sel_e reg_select(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        case (addr)
            PROP_LO_OFF:  sel = SEL_PROP_LO;
            PROP_HI_OFF:  sel = SEL_PROP_HI;
            MASK0_LO_OFF: sel = SEL_MASK0_LO;
            MASK0_HI_OFF: sel = SEL_MASK0_HI;
            MASK1_LO_OFF: sel = SEL_MASK1_LO;
            MASK1_HI_OFF: sel = SEL_MASK1_HI;
            OVERRIDE_OFF: sel = SEL_OVERRIDE;
            default:      sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    // override opens the data registers only, never itself
    function automatic logic access_ok(input reg_sel_e sel, input logic secure,
                                       input logic override_en);
        return secure || (override_en && (sel != SEL_OVERRIDE));
    endfunction

    // reserved bits keep their old value, which is always zero
    function automatic logic [63:0] merge_word(input logic [63:0]       old,
                                               input logic [DATA_W-1:0] data,
                                               input logic [3:0]        strb,
                                               input logic              hi,
                                               input logic [63:0]       wmask);
        logic [63:0] upd;
        upd = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                if (hi) begin
                    upd[32 + 8*b +: 8] = data[8*b +: 8];
                end else begin
                    upd[8*b +: 8] = data[8*b +: 8];
                end
            end
        end
        return (upd & wmask) | (old & ~wmask);
    endfunction

    function automatic logic [DATA_W-1:0] read_word(input reg_sel_e    sel,
                                                    input logic [63:0] props,
                                                    input logic [63:0] mask0,
                                                    input logic [63:0] mask1,
                                                    input logic        override_en);
        logic [DATA_W-1:0] word;
        word = '0;
        case (sel)
            SEL_PROP_LO:  word = props[31:0];
            SEL_PROP_HI:  word = props[63:32];
            SEL_MASK0_LO: word = mask0[31:0];
            SEL_MASK0_HI: word = mask0[63:32];
            SEL_MASK1_LO: word = mask1[31:0];
            SEL_MASK1_HI: word = mask1[63:32];
            SEL_OVERRIDE: word[OVERRIDE_POS] = override_en;
            default:      word = '0;
        endcase
        return word;
    endfunction

    assign wr_sel  = reg_select(st.aw_addr);
    assign rd_sel  = reg_select(araddr);
    assign wr_ok   = access_ok(wr_sel, st.aw_secure, st.override_en);
    assign rd_ok   = access_ok(rd_sel, ~arprot[1], st.override_en);
    assign wr_fire = st.aw_have && st.w_have && !st.bvalid;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;

        // mask before hash; hashing itself lives downstream
        next_st.masked.valid = hash_req.valid;
        if (hash_req.valid) begin
            next_st.masked.grp0 = hash_req.addr[MASK_MSB:MASK_LSB]
                                  & st.mask0[MASK_MSB:MASK_LSB];
            next_st.masked.grp1 = hash_req.addr[MASK_MSB:MASK_LSB]
                                  & st.mask1[MASK_MSB:MASK_LSB];
        end

        if (awvalid && st.awready) begin
            next_st.awready   = 1'b0;
            next_st.aw_have   = 1'b1;
            next_st.aw_addr   = awaddr;
            next_st.aw_secure = ~awprot[1];
        end
        if (wvalid && st.wready) begin
            next_st.wready = 1'b0;
            next_st.w_have = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end

        if (wr_fire) begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            if (wr_sel == SEL_NONE) begin
                next_st.bresp = RESP_DECERR;
            end else if (!wr_ok) begin
                next_st.bresp = RESP_SLVERR;
            end else begin
                next_st.bresp = RESP_OKAY;
                case (wr_sel)
                    SEL_PROP_LO: begin
                        next_st.props = merge_word(st.props, st.w_data, st.w_strb,
                                                   1'b0, PROP_WMASK);
                    end
                    SEL_PROP_HI: begin
                        next_st.props = merge_word(st.props, st.w_data, st.w_strb,
                                                   1'b1, PROP_WMASK);
                    end
                    SEL_MASK0_LO: begin
                        next_st.mask0 = merge_word(st.mask0, st.w_data, st.w_strb,
                                                   1'b0, MASK_WMASK);
                    end
                    SEL_MASK0_HI: begin
                        next_st.mask0 = merge_word(st.mask0, st.w_data, st.w_strb,
                                                   1'b1, MASK_WMASK);
                    end
                    SEL_MASK1_LO: begin
                        next_st.mask1 = merge_word(st.mask1, st.w_data, st.w_strb,
                                                   1'b0, MASK_WMASK);
                    end
                    SEL_MASK1_HI: begin
                        next_st.mask1 = merge_word(st.mask1, st.w_data, st.w_strb,
                                                   1'b1, MASK_WMASK);
                    end
                    SEL_OVERRIDE: begin
                        if (st.w_strb[0]) begin
                            next_st.override_en = st.w_data[OVERRIDE_POS];
                        end
                    end
                    default: begin
                        next_st.bresp = RESP_DECERR;
                    end
                endcase
            end
        end

        // ready reopens only after the response is taken: one write at a time
        if (st.bvalid && bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end

        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            if (rd_sel == SEL_NONE) begin
                next_st.rdata = '0;
                next_st.rresp = RESP_DECERR;
            end else if (!rd_ok) begin
                next_st.rdata = '0;
                next_st.rresp = RESP_SLVERR;
            end else begin
                next_st.rdata = read_word(rd_sel, st.props, st.mask0, st.mask1,
                                          st.override_en);
                next_st.rresp = RESP_OKAY;
            end
        end
        if (st.rvalid && rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st                     <= '0;
            st.awready             <= 1'b1;
            st.wready              <= 1'b1;
            st.arready             <= 1'b1;
            st.props               <= PROP_RESET;
            st.mask0               <= {12'h000, MASK0_FIELD_RESET, 6'h00};
            st.mask1               <= {12'h000, MASK1_FIELD_RESET, 6'h00};
            st.override_en         <= OVERRIDE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign awready         = st.awready;
    assign wready          = st.wready;
    assign arready         = st.arready;
    assign bvalid          = st.bvalid;
    assign bresp           = st.bresp;
    assign rvalid          = st.rvalid;
    assign rresp           = st.rresp;
    assign rdata           = st.rdata;
    assign masked_addr     = st.masked;
    assign secure_override = st.override_en;

    // newer-protocol flags at NEWER_POS are stored only, nothing taps them
    genvar t;
    generate
        for (t = 0; t < NUM_TARGETS + NUM_RANGE; t++) begin : g_target
            if (t < NUM_TARGETS) begin : g_num
                assign target_meta_terminate[t] =
                    st.props[t*TARGET_STRIDE + META_POS];
                assign target_group_select[t] =
                    st.props[t*TARGET_STRIDE + GROUP_POS];
            end else begin : g_rng
                assign range_target_meta_terminate[t-NUM_TARGETS] =
                    st.props[t*TARGET_STRIDE + META_POS];
                assign range_target_group_select[t-NUM_TARGETS] =
                    st.props[t*TARGET_STRIDE + GROUP_POS];
            end
        end
    endgenerate

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_nonsec_write_blocked: assert property (
        (wr_fire && !wr_ok && wr_sel != SEL_NONE) |=> $stable(st.props) && $stable(st.mask0)
                                && $stable(st.mask1) && bresp == RESP_SLVERR)
        else $error("non-secure write changed a register");

    a_nonsec_read_zero: assert property (
        (arvalid && arready && rd_sel != SEL_NONE && !rd_ok)
        |=> rvalid && rdata == 32'h0000_0000 && rresp == RESP_SLVERR)
        else $error("non-secure read returned data");

    a_meta_num_write: assert property (
        (wr_fire && wr_ok && wr_sel == SEL_PROP_LO && st.w_strb[0])
        |=> target_meta_terminate[0] == $past(st.w_data[META_POS]))
        else $error("target 0 terminate did not follow write");

    a_meta_range_write: assert property (
        (wr_fire && wr_ok && wr_sel == SEL_PROP_HI && st.w_strb[2])
        |=> range_target_meta_terminate[0] == $past(st.w_data[18]))
        else $error("range 0 terminate did not follow write");

    a_group_sel_write: assert property (
        (wr_fire && wr_ok && wr_sel == SEL_PROP_LO && st.w_strb[1])
        |=> target_group_select[1] == $past(st.w_data[9]))
        else $error("target 1 group select did not follow write");

    a_newer_flag_inert: assert property (
        $changed(st.props[NEWER_POS]) && $stable(st.props[63:1])
        |-> $stable(target_meta_terminate) && $stable(target_group_select))
        else $error("newer protocol flag affected outputs");

    a_props_reset_zero: assert property (
        disable iff (1'b0) !aresetn |=> st.props == 64'h0)
        else $error("property register not zero after reset");

    a_mask_applied: assert property (
        hash_req.valid |=> masked_addr.valid
        && masked_addr.grp0 == ($past(hash_req.addr[MASK_MSB:MASK_LSB])
                                & $past(st.mask0[MASK_MSB:MASK_LSB]))
        && masked_addr.grp1 == ($past(hash_req.addr[MASK_MSB:MASK_LSB])
                                & $past(st.mask1[MASK_MSB:MASK_LSB])))
        else $error("masked address mismatch");

    a_mask0_reset: assert property (
        disable iff (1'b0) !aresetn |=> st.mask0 == 64'h0000_FFFF_FFFF_FFC0)
        else $error("group 0 mask reset value wrong");

    a_mask1_reset: assert property (
        disable iff (1'b0) !aresetn |=> st.mask1 == 64'h0000_0FFF_FFFF_FFC0)
        else $error("group 1 mask reset value wrong");

    a_reserved_zero: assert property (
        (st.props & ~PROP_WMASK) == 64'h0 && (st.mask0 & ~MASK_WMASK) == 64'h0
        && (st.mask1 & ~MASK_WMASK) == 64'h0)
        else $error("reserved bit became set");

    a_override_opens: assert property (
        (wr_fire && !st.aw_secure && st.override_en && wr_sel < SEL_OVERRIDE)
        |=> bresp == RESP_OKAY && bvalid)
        else $error("override did not open non-secure write");

endmodule

// ==== test/tb_home_node_target_property_regs.sv ====
`timescale 1ns/1ps
module tb_home_node_target_property_regs import home_node_regs_pkg::*;;
    // ****
    // signals and bench model
    // ****
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, secure_override;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [2:0]        awprot, arprot;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rmt, rgs;
    logic [5:0]        tmt, tgs;
    hash_req_s         hash_req, hr, ph;
    masked_addr_s      masked_addr;
    logic [63:0]       mreg [3];
    logic [45:0]       g0, g1;
    logic [11:0]       addrs [7];
    logic              movr;
    int                bad_count, tests_run, seed, k;

    home_node_target_property_regs DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hash_req(hash_req), .masked_addr(masked_addr),
        .target_meta_terminate(tmt), .range_target_meta_terminate(rmt),
        .target_group_select(tgs), .range_target_group_select(rgs),
        .secure_override(secure_override));

    always #5 aclk = ~aclk;

    // ****
    // tasks
    // ****
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            bad_count++;
            $display("timeout at %0t", $time);
            conclude();
        end
    endtask

    function automatic int slot(input logic [11:0] a);
        case (a & 12'hFFB)
            PROP_LO_OFF:  return 0;
            MASK0_LO_OFF: return 1;
            MASK1_LO_OFF: return 2;
            default:      return 3;
        endcase
    endfunction

    // override word itself never opens to non-secure callers
    function automatic logic [1:0] gate(input logic [11:0] a, input logic [2:0] p);
        if (a == OVERRIDE_OFF) return p[1] ? RESP_SLVERR : RESP_OKAY;
        if (slot(a) == 3) return RESP_DECERR;
        return (p[1] && !movr) ? RESP_SLVERR : RESP_OKAY;
    endfunction

    function automatic logic [31:0] mdata(input logic [11:0] a);
        if (a == OVERRIDE_OFF) return {31'h0, movr};
        if (slot(a) == 3) return 32'h0;
        return a[2] ? mreg[slot(a)][63:32] : mreg[slot(a)][31:0];
    endfunction

    task automatic outs();
        logic [5:0] em, eg;
        for (int n = 0; n < 6; n++) begin
            em[n] = mreg[0][8*n+2];
            eg[n] = mreg[0][8*n+1];
        end
        check(tmt, em);
        check(tgs, eg);
        check(rmt, {mreg[0][58], mreg[0][50]});
        check(rgs, {mreg[0][57], mreg[0][49]});
        check(secure_override, movr);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s,
                      input logic [2:0] p);
        logic [63:0] bm;
        logic [1:0]  er, r;
        logic        pa, pw, ta, tw, got;
        er = gate(a, p);
        bm = '0;
        for (int n = 0; n < 4; n++) begin
            if (s[n]) bm[8*n+:8] = 8'hFF;
        end
        if (a[2]) bm = bm << 32;
        @(posedge aclk);
        awaddr <= a;
        awprot <= p;
        wdata <= dv;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        got = 1'b0;
        for (int n = 0; n < 50 && (pa || pw); n++) begin
            @(negedge aclk);
            ta = awready;
            tw = wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        guard(!(pa || pw));
        for (int n = 0; n < 50 && !got; n++) begin
            @(negedge aclk);
            got = bvalid;
            r = bresp;
            @(posedge aclk);
        end
        bready <= 1'b0;
        guard(got);
        check(r, er);
        if (er == RESP_OKAY && a == OVERRIDE_OFF && s[0]) movr = dv[0];
        else if (er == RESP_OKAY && slot(a) < 3) begin
            bm = bm & (slot(a) == 0 ? PROP_WMASK : MASK_WMASK);
            mreg[slot(a)] = (mreg[slot(a)] & ~bm) | ({dv, dv} & bm);
        end
        outs();
    endtask

    task automatic rd(input logic [11:0] a, input logic [2:0] p, output logic [31:0] dv);
        logic [1:0] r;
        logic       pa, ta, got;
        @(posedge aclk);
        araddr <= a;
        arprot <= p;
        arvalid <= 1'b1;
        rready <= 1'b1;
        pa = 1'b1;
        got = 1'b0;
        for (int n = 0; n < 50 && pa; n++) begin
            @(negedge aclk);
            ta = arready;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            pa = !ta;
        end
        guard(!pa);
        for (int n = 0; n < 50 && !got; n++) begin
            @(negedge aclk);
            got = rvalid;
            r = rresp;
            dv = rdata;
            @(posedge aclk);
        end
        rready <= 1'b0;
        guard(got);
        check(r, gate(a, p));
    endtask

    // refused and unmapped reads must return zero, not stale data
    task automatic rchk(input logic [11:0] a, input logic [2:0] p);
        logic [31:0] dv;
        rd(a, p, dv);
        check(dv, gate(a, p) == RESP_OKAY ? mdata(a) : 32'h0);
    endtask

    task automatic model_reset();
        {ph, g0, g1, movr} = '0;
        mreg[0] = PROP_RESET;
        mreg[1] = {12'h0, MASK0_FIELD_RESET, 6'h0};
        mreg[2] = {12'h0, MASK1_FIELD_RESET, 6'h0};
    endtask

    // last pass leaves the request idle so later mask writes precede traffic
    task automatic hash(input int cnt);
        for (int i = 0; i <= cnt; i++) begin
            @(posedge aclk);
            hr = {1'($urandom_range(0, 1)), 20'($urandom), 32'($urandom)};
            if (i == cnt) hr = '0;
            hash_req <= hr;
            @(negedge aclk);
            if (ph.valid) begin
                g0 = ph.addr[51:6] & mreg[1][51:6];
                g1 = ph.addr[51:6] & mreg[2][51:6];
            end
            check(masked_addr.valid, ph.valid);
            check(masked_addr.grp0, g0);
            check(masked_addr.grp1, g1);
            ph = hr;
        end
        $display("test hash masking done");
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
        hash_req = '0;
        {bad_count, tests_run} = '0;
        seed = $urandom(32'hF314D462);
        model_reset();
        addrs = '{PROP_LO_OFF, PROP_HI_OFF, MASK0_LO_OFF, MASK0_HI_OFF, MASK1_LO_OFF,
                  MASK1_HI_OFF, OVERRIDE_OFF};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(PROP_LO_OFF, 3'h0, d);
        check(d, 32'h0);
        rd(PROP_HI_OFF, 3'h0, d);
        check(d, 32'h0);
        rd(MASK0_LO_OFF, 3'h0, d);
        check(d, 32'hFFFFFFC0);
        rd(MASK0_HI_OFF, 3'h0, d);
        check(d, 32'h0000FFFF);
        rd(MASK1_LO_OFF, 3'h0, d);
        check(d, 32'hFFFFFFC0);
        rd(MASK1_HI_OFF, 3'h0, d);
        check(d, 32'h00000FFF);
        outs();
        hash(20);
        $display("test reset values done");
        // fresh reset: every mask write of this run comes before hash traffic
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        model_reset();
        rchk(MASK1_HI_OFF, 3'h0);
        rchk(MASK0_HI_OFF, 3'h0);
        outs();
        $display("test mid-run reset done");
        foreach (addrs[i]) begin
            wr(addrs[i], 32'hFFFFFFFF, 4'hF, 3'h0);
            rchk(addrs[i], 3'h0);
        end
        $display("test all ones done");
        wr(OVERRIDE_OFF, 32'h0, 4'hF, 3'h0);
        wr(PROP_LO_OFF, 32'h0, 4'hF, 3'h2);
        rchk(PROP_LO_OFF, 3'h2);
        wr(OVERRIDE_OFF, 32'h1, 4'hF, 3'h2);
        wr(12'h100, 32'h5A5A5A5A, 4'hF, 3'h0);
        rchk(12'h100, 3'h0);
        wr(OVERRIDE_OFF, 32'h1, 4'hF, 3'h0);
        wr(PROP_HI_OFF, 32'h0, 4'hF, 3'h2);
        rchk(PROP_HI_OFF, 3'h2);
        $display("test access control done");
        for (int i = 0; i < 80; i++) begin
            k = $urandom_range(0, 6);
            wr(addrs[k], $urandom, 4'($urandom), 3'($urandom));
            rchk(addrs[$urandom_range(0, 6)], 3'($urandom));
        end
        $display("test random access done");
        hash(40);
        conclude();
    end
endmodule
